// ===== logic/fpm_pkg.sv
package fpm_pkg;
	// ----------------------------------------
	// pin widths, command codes and the mode strap code
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_STATUS = 8'h71;
	localparam logic [3:0] STRAP_PLL_X2 = 4'hD;

	// ----------------------------------------
	// page layout
	// ----------------------------------------
	localparam int PAGE_BYTES = 128;
	localparam logic [7:0] PAGE_LOW_A = 8'h00;
	localparam logic [7:0] PAGE_LOW_B = 8'h80;

	// ----------------------------------------
	// status byte fields
	// ----------------------------------------
	localparam int ST_BIT_ABNORMAL = 7;
	localparam int ST_BIT_CMD_ERR = 6;
	localparam int ST_BIT_PROG_ERR = 5;
	localparam int ST_BIT_ERASE_ERR = 4;
	localparam int ST_BIT_COUNT_ERR = 1;
	localparam int ST_BIT_ADDR_ERR = 0;
	localparam int POLL_BIT_PROGRESS = 7;
	localparam int POLL_BIT_RESULT = 6;
	localparam logic [7:0] STATUS_RST = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_KHZ = 20000;
	localparam int PROG_MAX_MS = 3000;
	localparam int ERASE_MAX_MS = 40000;
	localparam int PROG_MAX_CYC = PROG_MAX_MS * CLK_KHZ;
	localparam int ERASE_MAX_CYC = ERASE_MAX_MS * CLK_KHZ;
	localparam int TMO_W = 30;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpm_beat_type;

	typedef enum logic [7:0] {
		ST_READ = 8'h01,
		ST_CMD2 = 8'h02,
		ST_LOAD = 8'h04,
		ST_DRAIN = 8'h08,
		ST_PROG = 8'h10,
		ST_ERASE = 8'h20,
		ST_POLL = 8'h40,
		ST_STATUS = 8'h80
	} fpm_state_type;
endpackage

// ===== logic/fpm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module fpm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	logic [W-1:0] stage1_reg;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stage1_reg <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// ===== logic/fpm_buf.sv
`timescale 1ns/10ps
`default_nettype none
module fpm_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// ----------------------------------------
	// small fifo
	// ----------------------------------------
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// sized one bit wider than the pointers so that a full buffer does not wrap to zero
	localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count_reg != FULL_CNT);
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	always_ff @(posedge mclk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= bump(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= bump(rd_ptr_reg);
			count_reg <= count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end
endmodule
`default_nettype wire

// ===== logic/fpm_port.sv
`timescale 1ns/10ps
`default_nettype none
module fpm_port #(
	parameter int PROG_TMO_CYC = fpm_pkg::PROG_MAX_CYC,
	parameter int ERASE_TMO_CYC = fpm_pkg::ERASE_MAX_CYC,
	parameter int BUF_DEPTH = 2
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] mode_strap_pins,
	input wire logic flash_write_guard_pin,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic wr_strobe_n,
	input wire logic [fpm_pkg::ADDR_W-1:0] location_pins,
	input wire logic [fpm_pkg::DATA_W-1:0] byte_lane_pins_in,
	output logic [fpm_pkg::DATA_W-1:0] byte_lane_pins_out,
	output logic byte_lane_pins_oe,
	output logic [fpm_pkg::ADDR_W-1:0] core_rd_addr,
	input wire logic [fpm_pkg::DATA_W-1:0] core_rd_data,
	output logic beat_valid,
	input wire logic beat_ready,
	output fpm_pkg::fpm_beat_type beat_out,
	output logic core_prog_go,
	output logic core_erase_go,
	input wire logic core_done,
	input wire logic core_fail,
	output logic programmer_active,
	output logic [fpm_pkg::DATA_W-1:0] status_byte
);
	import fpm_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int CW = 3 + 1 + 4;
	logic [CW-1:0] ctl_s;
	logic [ADDR_W-1:0] loc_s;
	logic [DATA_W-1:0] dat_s;

	// strobes idle high; write allow idles low, so nothing is armed until the pin is seen
	fpm_sync #(.W(CW), .RST_VAL(8'hE0)) u_sync_ctl (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({chip_sel_n, out_en_n, wr_strobe_n, flash_write_guard_pin, mode_strap_pins}),
		.sync_out(ctl_s)
	);
	fpm_sync #(.W(ADDR_W + DATA_W), .RST_VAL('0)) u_sync_bus (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({location_pins, byte_lane_pins_in}),
		.sync_out({loc_s, dat_s})
	);

	// ----------------------------------------
	// bus cycle decode
	// ----------------------------------------
	wire cs_s = ~ctl_s[7];
	wire oe_s = ~ctl_s[6];
	wire we_s = ~ctl_s[5];
	wire write_allow = ctl_s[4];
	wire straps_ok = (ctl_s[3:0] == STRAP_PLL_X2);
	wire read_cycle = cs_s && oe_s && !we_s;
	logic we_d_reg;
	logic [DATA_W-1:0] cap_data_reg;
	logic [ADDR_W-1:0] cap_addr_reg;
	// the write is taken on the strobe's rising edge, using what was held while it was low
	wire cmd_write = we_d_reg && !we_s && cs_s && !oe_s && straps_ok;
	wire [DATA_W-1:0] wdata = cap_data_reg;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			we_d_reg <= 1'b0;
			cap_data_reg <= '0;
			cap_addr_reg <= '0;
		end
		else
		begin
			we_d_reg <= we_s;
			if (we_s)
			begin
				cap_data_reg <= dat_s;
				cap_addr_reg <= loc_s;
			end
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	fpm_state_type state_reg, state_next;
	logic [7:0] first_code_reg;
	logic [7:0] beat_cnt_reg;
	logic [TMO_W-1:0] tmo_reg;
	logic [DATA_W-1:0] stat_reg;
	logic result_bad_reg;
	logic buf_in_ready;
	logic buf_out_valid;

	wire is_known = (wdata == CMD_READ) || (wdata == CMD_PROG) ||
		(wdata == CMD_ERASE) || (wdata == CMD_STATUS);
	wire busy = (state_reg == ST_DRAIN) || (state_reg == ST_PROG) || (state_reg == ST_ERASE);
	wire load_push = (state_reg == ST_LOAD) && cmd_write;
	wire first_beat = load_push && (beat_cnt_reg == '0);
	wire last_beat = load_push && (beat_cnt_reg == 8'(PAGE_BYTES - 1));
	wire addr_bad = (wdata != wdata) || ((cap_addr_reg[7:0] != PAGE_LOW_A) &&
		(cap_addr_reg[7:0] != PAGE_LOW_B));
	wire second_ok = (wdata == first_code_reg);
	wire tmo_hit = (tmo_reg == '0);
	wire op_end = busy && (state_reg != ST_DRAIN) && (core_done || tmo_hit);
	wire drain_done = (state_reg == ST_DRAIN) && !buf_out_valid;

	function automatic logic write_allow_ok(input logic [7:0] code);
		write_allow_ok = write_allow || !((code == CMD_PROG) || (code == CMD_ERASE));
	endfunction

	// a command during an operation is refused, never allowed to break the array timing
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_READ, ST_POLL, ST_STATUS:
				if (cmd_write && write_allow_ok(wdata))
				begin
					if (wdata == CMD_READ)
						state_next = ST_READ;
					else if (wdata == CMD_PROG)
						state_next = ST_LOAD;
					else if (is_known)
						state_next = ST_CMD2;
				end
			ST_CMD2:
				if (cmd_write)
				begin
					if (!second_ok)
						state_next = ST_READ;
					else if (first_code_reg == CMD_ERASE)
						state_next = ST_ERASE;
					else
						state_next = ST_STATUS;
				end
			ST_LOAD:
				if (last_beat)
					state_next = ST_DRAIN;
			ST_DRAIN:
				if (drain_done)
					state_next = ST_PROG;
			ST_PROG, ST_ERASE:
				if (op_end)
					state_next = ST_POLL;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state_reg <= ST_READ;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------
	// counters and error flags
	// ----------------------------------------
	wire start_op = (state_next == ST_PROG && state_reg == ST_DRAIN) ||
		(state_next == ST_ERASE && state_reg == ST_CMD2);
	wire refused = cmd_write && (busy || ((state_reg != ST_LOAD) && (state_reg != ST_CMD2) &&
		(!is_known || !write_allow_ok(wdata))));
	wire bad_second = cmd_write && (state_reg == ST_CMD2) && !second_ok;
	wire overrun = load_push && !buf_in_ready;
	wire new_page = cmd_write && (state_reg != ST_CMD2) && !busy && (wdata == CMD_PROG) &&
		(state_reg != ST_LOAD) && write_allow;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			first_code_reg <= '0;
			beat_cnt_reg <= '0;
			tmo_reg <= '0;
		end
		else
		begin
			if (cmd_write && state_reg != ST_CMD2)
				first_code_reg <= wdata;
			if (new_page)
				beat_cnt_reg <= '0;
			else if (load_push)
				beat_cnt_reg <= beat_cnt_reg + 8'h01;
			if (start_op)
				tmo_reg <= (state_next == ST_PROG) ? TMO_W'(PROG_TMO_CYC) : TMO_W'(ERASE_TMO_CYC);
			else if (!tmo_hit)
				tmo_reg <= tmo_reg - 1'b1;
		end
	end

	// status is kept across reads and chip disable; a new program or erase starts it afresh
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			stat_reg <= STATUS_RST;
			result_bad_reg <= 1'b0;
		end
		else
		begin
			if (new_page || (start_op && state_next == ST_ERASE))
				stat_reg <= STATUS_RST;
			if (first_beat && addr_bad)
				stat_reg[ST_BIT_ADDR_ERR] <= 1'b1;
			if (overrun)
				stat_reg[ST_BIT_PROG_ERR] <= 1'b1;
			if (refused || bad_second)
				stat_reg[ST_BIT_CMD_ERR] <= 1'b1;
			if (op_end && tmo_hit)
				stat_reg[ST_BIT_COUNT_ERR] <= 1'b1;
			if (op_end && (core_fail || tmo_hit))
			begin
				if (state_reg == ST_PROG)
					stat_reg[ST_BIT_PROG_ERR] <= 1'b1;
				else
					stat_reg[ST_BIT_ERASE_ERR] <= 1'b1;
			end
			if (op_end)
				result_bad_reg <= core_fail || tmo_hit || (|stat_reg[ST_BIT_PROG_ERR:0]);
			if (op_end && (core_fail || tmo_hit || (|stat_reg[ST_BIT_PROG_ERR:0])))
				stat_reg[ST_BIT_ABNORMAL] <= 1'b1;
		end
	end

	// ----------------------------------------
	// page beat buffer
	// ----------------------------------------
	// a stall that outlasts the buffer is not visible on the pins; it is recorded as an error
	fpm_buf #(.W($bits(fpm_beat_type)), .DEPTH(BUF_DEPTH)) u_buf (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(load_push),
		.in_ready(buf_in_ready),
		.in_data({cap_addr_reg, wdata}),
		.out_valid(buf_out_valid),
		.out_ready(beat_ready),
		.out_data(beat_out)
	);
	assign beat_valid = buf_out_valid;

	// ----------------------------------------
	// read data and pin drive
	// ----------------------------------------
	logic [DATA_W-1:0] rd_out_reg;
	logic oe_reg;
	logic prog_go_reg;
	logic erase_go_reg;
	wire [DATA_W-1:0] poll_byte = {!busy, busy ? 1'b0 : result_bad_reg, 6'h00};
	wire [DATA_W-1:0] rd_mux = (state_reg == ST_READ) ? core_rd_data :
		(state_reg == ST_STATUS) ? stat_reg : poll_byte;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rd_out_reg <= '0;
			oe_reg <= 1'b0;
			prog_go_reg <= 1'b0;
			erase_go_reg <= 1'b0;
		end
		else
		begin
			rd_out_reg <= rd_mux;
			oe_reg <= read_cycle && straps_ok;
			prog_go_reg <= start_op && (state_next == ST_PROG);
			erase_go_reg <= start_op && (state_next == ST_ERASE);
		end
	end

	assign byte_lane_pins_out = rd_out_reg;
	assign byte_lane_pins_oe = oe_reg && read_cycle;
	assign core_rd_addr = loc_s;
	assign core_prog_go = prog_go_reg;
	assign core_erase_go = erase_go_reg;
	assign programmer_active = straps_ok;
	assign status_byte = stat_reg;
endmodule
`default_nettype wire

// ===== dv/fpm_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fpm_port_properties (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] mode_strap_pins,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic wr_strobe_n,
	input wire logic [fpm_pkg::ADDR_W-1:0] location_pins,
	input wire logic byte_lane_pins_oe,
	input wire logic [fpm_pkg::ADDR_W-1:0] core_rd_addr,
	input wire logic beat_valid,
	input wire logic beat_ready,
	input wire fpm_pkg::fpm_beat_type beat_out,
	input wire logic core_prog_go,
	input wire logic core_erase_go,
	input wire logic programmer_active
);
	import fpm_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// ----------------
	// pin bus
	// ----------------
	// repeat counts cover the two synchroniser stages; the write check has no cycle to spare, the others one to three
	sequence rd_hold_s;
		(!chip_sel_n && !out_en_n && wr_strobe_n && programmer_active) [*5];
	endsequence
	sequence desel_s;
		chip_sel_n [*5];
	endsequence
	read_drive_a: assert property (rd_hold_s |-> byte_lane_pins_oe)
		else $error("read cycle left pins undriven");
	desel_float_a: assert property (desel_s |-> !byte_lane_pins_oe)
		else $error("pins driven while deselected");
	write_float_a: assert property ((!wr_strobe_n) [*3] |-> !byte_lane_pins_oe)
		else $error("pins driven during command write");
	addr_follow_a: assert property ($stable(location_pins) [*5] |-> core_rd_addr == location_pins)
		else $error("core address not following pins");
	strap_mode_a: assert property ((mode_strap_pins == STRAP_PLL_X2) [*4] |-> programmer_active)
		else $error("programmer mode not entered");
	// ----------------
	// core side
	// ----------------
	prog_pulse_a: assert property (core_prog_go |=> !core_prog_go)
		else $error("program start longer than one cycle");
	prog_drained_a: assert property (core_prog_go |-> !beat_valid)
		else $error("program started with beats pending");
	erase_pulse_a: assert property ($rose(core_erase_go) |=> $fell(core_erase_go))
		else $error("erase start longer than one cycle");
	go_exclusive_a: assert property (!(core_prog_go && core_erase_go))
		else $error("program and erase started together");
	beat_hold_a: assert property (beat_valid && !beat_ready |=> beat_valid && $stable(beat_out))
		else $error("stalled beat changed or dropped");
endmodule
bind fpm_port fpm_port_properties fpm_port_properties_inst (.mclk(mclk), .rst_n(rst_n),
	.mode_strap_pins(mode_strap_pins), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
	.wr_strobe_n(wr_strobe_n), .location_pins(location_pins),
	.byte_lane_pins_oe(byte_lane_pins_oe), .core_rd_addr(core_rd_addr),
	.beat_valid(beat_valid), .beat_ready(beat_ready), .beat_out(beat_out),
	.core_prog_go(core_prog_go), .core_erase_go(core_erase_go),
	.programmer_active(programmer_active));
`default_nettype wire

// ===== dv/fpm_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpm_core_model #(
	parameter int DLY = 60
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [fpm_pkg::ADDR_W-1:0] core_rd_addr,
	output logic [fpm_pkg::DATA_W-1:0] core_rd_data,
	input wire logic beat_valid,
	output logic beat_ready,
	input wire fpm_pkg::fpm_beat_type beat_out,
	input wire logic core_prog_go,
	input wire logic core_erase_go,
	output logic core_done,
	output logic core_fail,
	input wire logic stall,
	input wire logic fail_req
);
	import fpm_pkg::*;
	logic [DATA_W-1:0] pg [PAGE_BYTES];
	logic [ADDR_W-1:0] first_addr;
	logic erased = 1'b0;
	int nbeats = 0;
	int cnt = 0;
	assign beat_ready = !stall;
	// erase is whole-array only, so one flag covers every address
	assign core_rd_data = erased ? 8'hFF : core_rd_addr[7:0] ^ core_rd_addr[15:8];
	always @(posedge mclk)
	begin
		core_done <= 1'b0;
		if (!rst_n)
			core_fail <= 1'b0;
		else
		begin
			if (beat_valid && beat_ready)
			begin
				if (nbeats == 0)
					first_addr <= beat_out.addr;
				pg[nbeats % PAGE_BYTES] <= beat_out.data;
				nbeats <= nbeats + 1;
			end
			if (cnt > 0)
				cnt <= cnt - 1;
			if (core_prog_go || core_erase_go)
				cnt <= DLY;
			if (core_erase_go)
				erased <= !fail_req;
			if (cnt == 1)
			begin
				core_done <= 1'b1;
				core_fail <= fail_req;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fpm_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] mode_strap_pins = STRAP_PLL_X2;
	logic flash_write_guard_pin = 1'b1;
	logic chip_sel_n = 1'b1;
	logic out_en_n = 1'b1;
	logic wr_strobe_n = 1'b1;
	logic [ADDR_W-1:0] location_pins = '0;
	logic [DATA_W-1:0] byte_lane_pins_in = '0;
	logic stall = 1'b0;
	logic fail_req = 1'b0;
	logic [DATA_W-1:0] byte_lane_pins_out, core_rd_data, status_byte;
	logic [ADDR_W-1:0] core_rd_addr;
	logic byte_lane_pins_oe, beat_valid, beat_ready, core_prog_go, core_erase_go;
	logic core_done, core_fail, programmer_active;
	fpm_beat_type beat_out;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int erases = 0;
	always #25 mclk = ~mclk;
	fpm_port #(.PROG_TMO_CYC(400), .ERASE_TMO_CYC(400)) fpm_port_inst (.mclk, .rst_n,
		.mode_strap_pins, .flash_write_guard_pin, .chip_sel_n, .out_en_n, .wr_strobe_n,
		.location_pins, .byte_lane_pins_in, .byte_lane_pins_out, .byte_lane_pins_oe,
		.core_rd_addr, .core_rd_data, .beat_valid, .beat_ready, .beat_out, .core_prog_go,
		.core_erase_go, .core_done, .core_fail, .programmer_active, .status_byte);
	fpm_core_model #(.DLY(60)) fpm_core_model_inst (.mclk, .rst_n, .core_rd_addr,
		.core_rd_data, .beat_valid, .beat_ready, .beat_out, .core_prog_go, .core_erase_go,
		.core_done, .core_fail, .stall, .fail_req);
	// ----------------
	// pin tasks
	// ----------------
	function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ a[15:8];
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// data and address stay put until the write has been taken
	task automatic wr(input logic [7:0] d, input logic [ADDR_W-1:0] a);
		@(negedge mclk);
		chip_sel_n = 1'b0;
		location_pins = a;
		byte_lane_pins_in = d;
		wr_strobe_n = 1'b0;
		repeat (3) @(negedge mclk);
		wr_strobe_n = 1'b1;
		repeat (4) @(negedge mclk);
		chip_sel_n = 1'b1;
	endtask
	task automatic cmd2(input logic [7:0] c);
		wr(c, '0);
		wr(c, '0);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(negedge mclk);
		chip_sel_n = 1'b0;
		out_en_n = 1'b0;
		location_pins = a;
		repeat (6) @(negedge mclk);
		chk("pin drive", 8'h01, {7'h00, byte_lane_pins_oe});
		chk("read byte", exp, byte_lane_pins_out & mask);
		out_en_n = 1'b1;
		chip_sel_n = 1'b1;
		repeat (4) @(negedge mclk);
	endtask
	task automatic prog(input logic [ADDR_W-1:0] base);
		wr(CMD_PROG, '0);
		stall = 1'b1;
		for (int i = 0; i < PAGE_BYTES; i++)
		begin
			if (i == 2)
				stall = 1'b0;
			wr(i[7:0], base + ADDR_W'(i));
		end
		rd('0, 8'hFF, 8'h00);
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (core_done !== 1'b1 && n < 2000)
		begin
			@(negedge mclk);
			n++;
		end
		chk("core done", 8'h01, {7'h00, core_done});
		repeat (4) @(negedge mclk);
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (core_erase_go === 1'b1)
			erases++;
		if (cyc == 12000)
		begin
			err_count++;
			final_report();
		end
	end
	// ----------------
	// tests
	// ----------------
	initial
	begin
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		repeat (5) @(negedge mclk);
		rd(18'h00312, 8'hFF, pat(18'h00312));
		chk("status reset", STATUS_RST, status_byte);
		wr(CMD_READ, '0);
		rd(18'h2A5C3, 8'hFF, pat(18'h2A5C3));
		rd(18'h2A5C4, 8'hFF, pat(18'h2A5C4));
		wr(8'h55, '0);
		rd(18'h00007, 8'hFF, pat(18'h00007));
		cmd2(CMD_STATUS);
		rd('0, 8'hFF, 8'h40);
		$display("test read and unknown code done");
		prog(18'h00100);
		wait_done();
		rd('0, 8'hFF, 8'h80);
		rd('0, 8'hFF, 8'h80);
		chk("beat count", 8'h80, fpm_core_model_inst.nbeats[7:0]);
		chk("page base", 8'h01, fpm_core_model_inst.first_addr[15:8]);
		chk("page byte", 8'h4D, fpm_core_model_inst.pg[77]);
		cmd2(CMD_STATUS);
		rd('0, 8'hFF, 8'h00);
		fail_req = 1'b1;
		prog(18'h00310);
		wait_done();
		rd('0, 8'hFF, 8'hC0);
		cmd2(CMD_STATUS);
		rd('0, 8'hA1, 8'hA1);
		$display("test program done");
		flash_write_guard_pin = 1'b0;
		cmd2(CMD_ERASE);
		chk("guarded erase", 8'h00, erases[7:0]);
		flash_write_guard_pin = 1'b1;
		wr(CMD_ERASE, '0);
		wr(CMD_STATUS, '0);
		chk("mismatched erase", 8'h00, erases[7:0]);
		cmd2(CMD_ERASE);
		wait_done();
		chk("erase start", 8'h01, erases[7:0]);
		rd('0, 8'hFF, 8'hC0);
		cmd2(CMD_STATUS);
		rd('0, 8'h90, 8'h90);
		fail_req = 1'b0;
		cmd2(CMD_ERASE);
		wait_done();
		rd('0, 8'hFF, 8'h80);
		wr(CMD_READ, '0);
		rd(18'h3FFFF, 8'hFF, 8'hFF);
		rd(18'h00312, 8'hFF, 8'hFF);
		$display("test erase done");
		final_report();
	end
endmodule
`default_nettype wire
